// File: hw/nxh_pkg.sv
// package: constants for the nibble expander host controller
package nxh_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // device timing figures in ns (least times round up)
  localparam int unsigned T_CODE_SETUP_NS = 100;
  localparam int unsigned T_CODE_HOLD_NS  = 60;
  localparam int unsigned T_DATA_SETUP_NS = 200;
  localparam int unsigned T_DATA_HOLD_NS  = 20;
  localparam int unsigned T_STROBE_LOW_NS = 700;
  localparam int unsigned T_CS_NS         = 50;
  localparam int unsigned T_READ_ACC_NS   = 650;
  localparam int unsigned T_FLOAT_NS      = 150;
  localparam int unsigned T_CODE_SETUP_CYC = (T_CODE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CODE_HOLD_CYC  = (T_CODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_DATA_SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_DATA_HOLD_CYC  = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_STROBE_LOW_CYC = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CS_CYC         = (T_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read: wait out access time plus the three-flop input sampler
  localparam int unsigned T_READ_ACC_CYC   = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 3;
  localparam int unsigned T_FLOAT_CYC      = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 6;
  // command nibble fields
  localparam int unsigned PORT_LSB = 0;
  localparam int unsigned OP_LSB   = 2;
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_OR    = 2'h2;
  localparam logic [1:0] OP_AND   = 2'h3;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_SELECT = 8'h02,
    ST_CMD    = 8'h04,
    ST_CHOLD  = 8'h08,
    ST_LOW    = 8'h10,
    ST_RISE   = 8'h20,
    ST_DHOLD  = 8'h40,
    ST_DESEL  = 8'h80
  } nxh_state_t;
endpackage

// File: hw/nxh_sync.sv
// three-flop synchroniser for the nibble bus input
`timescale 1ns/10ps
module nxh_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk_in,   // system clock
  input  wire logic             rst_n_in, // async reset, active low
  input  wire logic [WIDTH-1:0] d_in,     // asynchronous input
  output logic      [WIDTH-1:0] q_out     // filtered value
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a change only once second and third stages agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_reg <= '0;
    end else if (s2_reg == s3_reg) begin
      q_reg <= s3_reg;
    end
  end

  assign q_out = q_reg;
endmodule // nxh_sync

// File: hw/nxh_host.sv
// host controller driving a four-port nibble i/o expander
//
// Overview of operation
// - host holds data nibble stable across the rising strobe edge.
// - each transfer is one command nibble then one data nibble.
// - host makes strobe pulse: fall marks command, rise marks data.
// - several expanders are selected by separate chip select lines.
// - host should discard first read after switching a port from write; this controller returns it flagged on rsp_stale_out.
`timescale 1ns/10ps
module nxh_host #(
  parameter int unsigned NUM_DEV = 1 // expanders sharing the nibble bus
) (
  input  wire logic                       clk_in,        // 25 MHz clock
  input  wire logic                       rst_n_in,      // async reset, active low
  input  wire logic                       req_valid_in,  // request present
  output logic                            req_ready_out, // request taken this cycle
  input  wire logic [1:0]                 req_op_in,     // 0 read 1 write 2 or 3 and
  input  wire logic [1:0]                 req_port_in,   // 0..3 selects port 4..7
  input  wire logic [$clog2(NUM_DEV+1)-1:0] req_dev_in,  // which expander
  input  wire logic [3:0]                 req_data_in,   // write nibble
  output logic                            rsp_valid_out, // one-cycle done pulse
  output logic [3:0]                      rsp_data_out,  // read nibble
  output logic                            rsp_stale_out, // first read after write
  output logic                            transfer_strobe_out, // strobe pin
  output logic [NUM_DEV-1:0]              chip_sel_n_out,      // chip selects, low active
  input  wire logic [3:0]                 nibble_bus_in,       // bus pin level
  output logic [3:0]                      nibble_bus_out,      // bus drive value
  output logic                            nibble_bus_oe_out    // high while host drives
);
  nxh_pkg::nxh_state_t state_reg;
  nxh_pkg::nxh_state_t state_next;
  logic [nxh_pkg::CNT_W-1:0] cnt_reg;
  logic [1:0]  op_reg;
  logic [1:0]  port_reg;
  logic [3:0]  data_reg;
  logic [NUM_DEV-1:0] sel_reg;
  logic [3:0]  bus_sync;
  logic [3:0]  nib_reg;
  logic        oe_reg;
  logic        strobe_reg;
  logic [NUM_DEV-1:0] cs_n_reg;
  logic [3:0]  rdata_reg;
  logic        rsp_reg;
  logic        stale_reg;
  logic [4*NUM_DEV-1:0] written_reg; // per port: last access was a write
  logic        cnt_done;
  logic        is_read;

  assign cnt_done = (cnt_reg == '0);
  assign is_read  = (op_reg == nxh_pkg::OP_READ);

  nxh_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (nibble_bus_in),
    .q_out    (bus_sync)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nxh_pkg::ST_IDLE:   if (req_valid_in) state_next = nxh_pkg::ST_SELECT;
      nxh_pkg::ST_SELECT: if (cnt_done) state_next = nxh_pkg::ST_CMD;
      nxh_pkg::ST_CMD:    if (cnt_done) state_next = nxh_pkg::ST_CHOLD;
      nxh_pkg::ST_CHOLD:  if (cnt_done) state_next = nxh_pkg::ST_LOW;
      nxh_pkg::ST_LOW:    if (cnt_done) state_next = nxh_pkg::ST_RISE;
      nxh_pkg::ST_RISE:   state_next = nxh_pkg::ST_DHOLD;
      nxh_pkg::ST_DHOLD:  if (cnt_done) state_next = nxh_pkg::ST_DESEL;
      nxh_pkg::ST_DESEL:  if (cnt_done) state_next = nxh_pkg::ST_IDLE;
      default:            state_next = nxh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= nxh_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // wait counter, loaded on each state entry
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      case (state_next)
        nxh_pkg::ST_SELECT: cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_CS_CYC);
        nxh_pkg::ST_CMD:    cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_CODE_SETUP_CYC);
        nxh_pkg::ST_CHOLD:  cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_CODE_HOLD_CYC);
        // low phase covers pulse width, data setup and read access
        nxh_pkg::ST_LOW:    cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_STROBE_LOW_CYC
                                        + nxh_pkg::T_READ_ACC_CYC);
        nxh_pkg::ST_DHOLD:  cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_DATA_HOLD_CYC
                                        + nxh_pkg::T_FLOAT_CYC);
        nxh_pkg::ST_DESEL:  cnt_reg <= nxh_pkg::CNT_W'(nxh_pkg::T_CS_CYC);
        default:            cnt_reg <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // request capture
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_reg   <= nxh_pkg::OP_READ;
      port_reg <= 2'h0;
      data_reg <= nxh_pkg::NIBBLE_RST;
      sel_reg  <= '0;
    end else if (state_reg == nxh_pkg::ST_IDLE && req_valid_in) begin
      op_reg   <= req_op_in;
      port_reg <= req_port_in;
      data_reg <= req_data_in;
      for (int i = 0; i < NUM_DEV; i++) begin
        sel_reg[i] <= (req_dev_in == i[$clog2(NUM_DEV+1)-1:0]);
      end
    end
  end

  // chip select frames the whole transfer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_reg <= '1;
    end else if (state_next == nxh_pkg::ST_IDLE || state_reg == nxh_pkg::ST_IDLE) begin
      // sel_reg is still the previous device on the take edge; wait a cycle to avoid selecting it
      cs_n_reg <= '1;
    end else begin
      cs_n_reg <= ~sel_reg;
    end
  end

  // strobe: falls after command setup, rises after low phase
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_reg <= 1'b1;
    end else begin
      strobe_reg <= !(state_next == nxh_pkg::ST_CHOLD || state_next == nxh_pkg::ST_LOW);
    end
  end

  // nibble bus drive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nib_reg <= nxh_pkg::NIBBLE_RST;
      oe_reg  <= 1'b0;
    end else begin
      case (state_next)
        nxh_pkg::ST_CMD, nxh_pkg::ST_CHOLD: begin
          nib_reg <= {op_reg, port_reg};
          oe_reg  <= 1'b1;
        end
        nxh_pkg::ST_LOW, nxh_pkg::ST_RISE, nxh_pkg::ST_DHOLD: begin
          nib_reg <= data_reg;
          oe_reg  <= !is_read;
        end
        default: begin
          nib_reg <= nib_reg;
          oe_reg  <= 1'b0;
        end
      endcase
    end
  end

  // read data sampled just before strobe rises
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= nxh_pkg::NIBBLE_RST;
    end else if (state_reg == nxh_pkg::ST_LOW && cnt_done && is_read) begin
      rdata_reg <= bus_sync;
    end
  end

  // track ports whose last access was a write, flag stale reads
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      written_reg <= '0;
      stale_reg   <= 1'b0;
    end else if (state_reg == nxh_pkg::ST_RISE) begin
      for (int d = 0; d < NUM_DEV; d++) begin
        if (sel_reg[d]) begin
          written_reg[4*d + int'(port_reg)] <= !is_read;
          if (is_read) begin
            stale_reg <= written_reg[4*d + int'(port_reg)];
          end
        end
      end
      if (!is_read) begin
        stale_reg <= 1'b0;
      end
    end
  end

  // done pulse on the same edge as chip select release, after bus floated
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_reg <= 1'b0;
    end else begin
      rsp_reg <= (state_reg == nxh_pkg::ST_DESEL && cnt_done);
    end
  end

  assign req_ready_out       = (state_reg == nxh_pkg::ST_IDLE);
  assign rsp_valid_out       = rsp_reg;
  assign rsp_data_out        = rdata_reg;
  assign rsp_stale_out       = stale_reg;
  assign transfer_strobe_out = strobe_reg;
  assign chip_sel_n_out      = cs_n_reg;
  assign nibble_bus_out      = nib_reg;
  assign nibble_bus_oe_out   = oe_reg;
endmodule // nxh_host

// File: bench/nxh_exp_model.sv
// behavioural model of the four-port nibble expander
`timescale 1ns/10ps
module nxh_exp_model (
  input  wire logic        strobe_in,  // transfer strobe
  input  wire logic        cs_n_in,    // chip select, low active
  input  wire logic [3:0]  bus_in,     // nibble bus level
  input  wire logic [15:0] ext_in,     // levels on floating port pins
  output logic      [3:0]  bus_out,    // read nibble
  output logic             bus_oe_out, // high while model drives bus
  output logic      [15:0] latch_out,  // port output latches
  output logic      [3:0]  drv_out     // port drives its latch
);
  logic [1:0] op_reg = 2'h0;
  logic [1:0] port_reg = 2'h0;
  logic       live_reg = 1'b0;
  logic [3:0] old;
  initial begin
    drv_out = 4'h0;
    bus_oe_out = 1'b0;
    latch_out = 16'h0;
  end
  assign bus_out = ext_in[port_reg*4 +: 4];
  always @(strobe_in) begin
    if (!cs_n_in && strobe_in === 1'b0) begin
      op_reg = bus_in[3:2];
      port_reg = bus_in[1:0];
      live_reg = 1'b1;
      if (bus_in[3:2] == 2'h0) begin
        drv_out[bus_in[1:0]] = 1'b0;
        bus_oe_out = 1'b1;
      end
    end else if (!cs_n_in && strobe_in === 1'b1 && live_reg) begin
      old = latch_out[port_reg*4 +: 4];
      case (op_reg)
        2'h1: latch_out[port_reg*4 +: 4] = bus_in;
        2'h2: latch_out[port_reg*4 +: 4] = old | bus_in;
        2'h3: latch_out[port_reg*4 +: 4] = old & bus_in;
        default: bus_oe_out = 1'b0;
      endcase
      if (op_reg != 2'h0) drv_out[port_reg] = 1'b1;
    end
  end
endmodule // nxh_exp_model

// File: bench/nxh_host_props.sv
// pin timing checks for the nibble expander host
`timescale 1ns/10ps
module nxh_host_props #(
  parameter int unsigned NUM_DEV = 1 // expanders on the bus
) (
  input wire logic               clk_in,              // clock
  input wire logic               rst_n_in,            // reset, active low
  input wire logic               req_valid_in,        // request present
  input wire logic               req_ready_out,       // request taken
  input wire logic               rsp_valid_out,       // done pulse
  input wire logic               transfer_strobe_out, // strobe pin
  input wire logic [NUM_DEV-1:0] chip_sel_n_out,      // chip selects
  input wire logic [3:0]         nibble_bus_out,      // bus drive value
  input wire logic               nibble_bus_oe_out    // bus drive enable
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] low_cnt;
  logic [1:0] fall_cnt;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt <= 8'h0;
    else if (transfer_strobe_out) low_cnt <= 8'h0;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fall_cnt <= 2'h0;
    else if (req_valid_in && req_ready_out) fall_cnt <= 2'h0;
    else if ($fell(transfer_strobe_out) && fall_cnt != 2'h3) fall_cnt <= fall_cnt + 2'h1;
  end
  cmd_setup_a: assert property ($fell(transfer_strobe_out) |-> nibble_bus_oe_out &&
    $past(nibble_bus_oe_out, 3) && $past(nibble_bus_out, 3) == nibble_bus_out) else $error("command setup short");
  cmd_hold_a: assert property ($fell(transfer_strobe_out) |=> nibble_bus_oe_out && $stable(nibble_bus_out))
    else $error("command hold short");
  cs_setup_a: assert property ($fell(transfer_strobe_out) |-> $onehot(~chip_sel_n_out) && $stable(chip_sel_n_out))
    else $error("chip select wrong at strobe fall");
  idle_high_a: assert property (&chip_sel_n_out |-> transfer_strobe_out) else $error("strobe low while deselected");
  low_width_a: assert property ($rose(transfer_strobe_out) |-> low_cnt >= 8'h12) else $error("strobe low too short");
  data_setup_a: assert property ($rose(transfer_strobe_out) && nibble_bus_oe_out |->
    $past(nibble_bus_oe_out, 5) && $past(nibble_bus_out, 5) == nibble_bus_out) else $error("data setup short");
  read_release_a: assert property ($fell(transfer_strobe_out) && nibble_bus_out[3:2] == nxh_pkg::OP_READ |->
    ##[1:4] !nibble_bus_oe_out) else $error("bus not released on read");
  float_wait_a: assert property ($rose(transfer_strobe_out) && !nibble_bus_oe_out |-> !nibble_bus_oe_out[*4])
    else $error("bus driven before float time");
  latency_a: assert property (req_valid_in && req_ready_out |-> ##[50:60] rsp_valid_out)
    else $error("response latency wrong");
  one_cmd_a: assert property (rsp_valid_out |-> fall_cnt == 2'h1) else $error("strobe count per transfer wrong");
endmodule // nxh_host_props

// File: bench/nxh_host_tb.sv
// self-checking bench for the nibble expander host
`timescale 1ns/10ps
module nxh_host_tb;
  logic        clk_in = 1'b0, rst_n_in, req_valid_in, req_ready_out, rsp_valid_out, rsp_stale_out;
  logic        transfer_strobe_out, nibble_bus_oe_out, dev_oe;
  logic [1:0]  req_op_in, req_port_in, req_dev_in, chip_sel_n_out;
  logic [3:0]  req_data_in, rsp_data_out, nibble_bus_out, dev_bus, drv, bus_lvl;
  logic [3:0]  idle_reg = 4'h5;
  logic [15:0] latch;
  logic [15:0] ext_val = 16'hb2d4;
  int          error_cnt = 0, checked = 0, cyc = 0;
  int          cs_fall0 = 0, cs_fall1 = 0;
  always #20 clk_in = ~clk_in;
  always @(negedge chip_sel_n_out[0]) cs_fall0++;
  always @(negedge chip_sel_n_out[1]) cs_fall1++;
  always @(posedge clk_in) idle_reg <= ~idle_reg;
  assign bus_lvl = nibble_bus_oe_out ? nibble_bus_out : (dev_oe ? dev_bus : idle_reg);
  nxh_host #(.NUM_DEV(2)) u_nxh_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_op_in(req_op_in), .req_port_in(req_port_in), .req_dev_in(req_dev_in),
    .req_data_in(req_data_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .rsp_stale_out(rsp_stale_out), .transfer_strobe_out(transfer_strobe_out), .chip_sel_n_out(chip_sel_n_out),
    .nibble_bus_in(bus_lvl), .nibble_bus_out(nibble_bus_out), .nibble_bus_oe_out(nibble_bus_oe_out));
  nxh_exp_model u_nxh_exp_model (.strobe_in(transfer_strobe_out), .cs_n_in(chip_sel_n_out[0]), .bus_in(bus_lvl),
    .ext_in(ext_val), .bus_out(dev_bus), .bus_oe_out(dev_oe), .latch_out(latch), .drv_out(drv));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [1:0] op, input logic [1:0] port, input logic [1:0] dev, input logic [3:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    {req_op_in, req_port_in, req_dev_in, req_data_in, req_valid_in} = {op, port, dev, d, 1'b1};
    @(posedge clk_in);
    @(negedge clk_in) req_valid_in = 1'b0;
    chk("ready busy", 16'h0, 16'(req_ready_out));
    while (rsp_valid_out !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk("done", 16'h1, 16'(rsp_valid_out));
    chk("ready at done", 16'h1, 16'(req_ready_out));
  endtask
  task automatic t_power();
    repeat (5) @(negedge clk_in);
    chk("port drive", 16'h0, 16'(drv));
    chk("bus drive", 16'h0, 16'(dev_oe));
    $display("test power done");
  endtask
  task automatic t_write();
    for (int p = 0; p < 4; p++) xfer(2'h1, 2'(p), 2'h0, 4'(5 + p));
    chk("latch write", 16'h8765, latch);
    xfer(2'h2, 2'h0, 2'h0, 4'ha);
    chk("latch or", {12'h876, 4'h5 | 4'ha}, latch);
    xfer(2'h3, 2'h0, 2'h0, 4'h6);
    chk("latch and", {12'h876, 4'hf & 4'h6}, latch);
    chk("port drive", 16'hf, 16'(drv));
    $display("test write done");
  endtask
  task automatic t_cs();
    int f0, f1;
    f0 = cs_fall0;
    f1 = cs_fall1;
    xfer(2'h1, 2'h2, 2'h1, 4'h1);
    chk("select 0 falls", 16'h0, 16'(cs_fall0 - f0));
    chk("select 1 falls", 16'h1, 16'(cs_fall1 - f1));
    chk("latch other device", 16'h8766, latch);
    chk("port drive", 16'hf, 16'(drv));
    $display("test select done");
  endtask
  task automatic t_read();
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 4; p++) begin
        xfer(2'h0, 2'(p), 2'h0, 4'h0);
        chk("read data", 16'(ext_val[p*4 +: 4]), 16'(rsp_data_out));
        chk("stale flag", 16'(k == 0), 16'(rsp_stale_out));
      end
    end
    chk("port drive", 16'h0, 16'(drv));
    chk("latch kept", 16'h8766, latch);
    xfer(2'h1, 2'h3, 2'h0, 4'hc);
    chk("latch rewrite", 16'hc766, latch);
    chk("port drive", 16'h8, 16'(drv));
    $display("test read done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    {rst_n_in, req_valid_in, req_op_in, req_port_in, req_dev_in, req_data_in} = 12'h0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_power();
    t_write();
    t_cs();
    t_read();
    print_verdict();
  end
endmodule // nxh_host_tb
bind nxh_host nxh_host_props #(.NUM_DEV(NUM_DEV)) u_nxh_host_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .transfer_strobe_out(transfer_strobe_out), .chip_sel_n_out(chip_sel_n_out), .nibble_bus_out(nibble_bus_out),
  .nibble_bus_oe_out(nibble_bus_oe_out));
